// >>> mrbp_rx_port.sv
// Receive byte port of a 10/100 Ethernet MAC with APB control registers
`timescale 1ns/1ps
`include "mrbp_regs.svh"
module mrbp_rx_port #(
	parameter int CLK_HZ  = `MRBP_CLK_HZ,
	parameter int MAX_LEN = `MRBP_MAX_LEN
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  rx_nibble,
	input  wire logic        rx_line_valid,
	input  wire logic        rx_line_error,
	input  wire logic        rx_carrier,
	output logic             rx_nibble_clock,
	output logic      [7:0]  rx_byte_bus,
	output logic             rx_byte_valid,
	output logic             rx_start_of_frame,
	output logic             rx_end_of_frame,
	output logic             rx_status_strobe
);
	// ****************************************
	// Derived counts and elaboration checks
	// ****************************************
	localparam int       SLOW_RAW = CLK_HZ / (2 * `MRBP_SLOW_HZ);
	localparam int       FAST_RAW = CLK_HZ / (2 * `MRBP_FAST_HZ);
	localparam logic [7:0] HALF_S = 8'(SLOW_RAW);
	localparam logic [7:0] HALF_F = 8'((FAST_RAW < 1) ? 1 : FAST_RAW);
	localparam logic [4:0] IPG_N  = 5'(`MRBP_IPG_BITS / `MRBP_BITS_PER_NIB);
	localparam logic [13:0] MAX_L = 14'(MAX_LEN);
	if (SLOW_RAW < 1 || SLOW_RAW > 255 || MAX_LEN < 64 || MAX_LEN > 16383) begin : g_bad
		$error("mrbp_rx_port: clock rate or length limit out of range");
	end

	// ****************************************
	// Control registers and APB slave
	// ****************************************
	logic [31:0] ctrl;
	logic [23:0] last_stat;
	logic [15:0] frame_cnt;
	logic        hit;
	logic        rx_en;
	logic        ovs_en;
	mrbp_pkg::mrbp_mode_t mode;

	assign rx_en  = ctrl[`MRBP_CTRL_EN_BIT];
	assign ovs_en = ctrl[`MRBP_CTRL_OVS_BIT];
	assign mode   = mrbp_pkg::mrbp_mode_t'(ctrl[`MRBP_CTRL_MODE_MSB:`MRBP_CTRL_MODE_LSB]);

	// Address decode
	always_comb begin
		if (paddr == `MRBP_CTRL_OFS) begin
			hit = 1'b1;
		end else if (paddr == `MRBP_STAT_OFS) begin
			hit = 1'b1;
		end else if (paddr == `MRBP_COUNT_OFS) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	// Zero wait states; unmapped access answers with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Control writes land in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `MRBP_CTRL_RST;
		end else if (clk_en && psel && penable && pwrite && paddr == `MRBP_CTRL_OFS) begin
			ctrl <= pwdata;
		end
	end

	// Read data captured in setup so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && psel && !penable && !pwrite) begin
			if (paddr == `MRBP_CTRL_OFS) begin
				prdata <= ctrl;
			end else if (paddr == `MRBP_STAT_OFS) begin
				prdata <= {8'h00, last_stat};
			end else if (paddr == `MRBP_COUNT_OFS) begin
				prdata <= {16'h0000, frame_cnt};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Nibble clock generator
	// ****************************************
	logic [7:0] half_cnt;
	logic       nclk;
	logic       expire;
	logic       tick_rise;
	logic       tick_fall;
	logic       phase;
	logic       slot;
	logic [7:0] half_len;

	// Fast modes need the short half period
	assign half_len  = (mode == mrbp_pkg::MRBP_CODED100 || mode == mrbp_pkg::MRBP_MII_FAST)
		? HALF_F : HALF_S;
	assign expire    = (half_cnt >= half_len - 8'h01);
	assign tick_rise = expire & ~nclk;
	assign tick_fall = expire & nclk;
	assign slot      = tick_fall & phase;
	assign rx_nibble_clock = nclk;

	// Divider toggles the clock every half period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt <= 8'h00;
			nclk     <= 1'b0;
		end else if (clk_en) begin
			if (expire) begin
				half_cnt <= 8'h00;
				nclk     <= ~nclk;
			end else begin
				half_cnt <= half_cnt + 8'h01;
			end
		end
	end

	// Byte slots on every second falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 1'b0;
		end else if (clk_en && tick_fall) begin
			phase <= ~phase;
		end
	end

	// ****************************************
	// Nibble front end
	// ****************************************
	mrbp_pkg::mrbp_asm_t asm_st;
	logic [4:0]  ipg_cnt;
	logic [3:0]  pre_cnt;
	logic [3:0]  lo_nib;
	logic        nib_hi;
	logic        byte_done;
	logic [7:0]  new_byte;
	logic        sfd_seen;
	logic        end_seen;
	logic        carrier_ev;
	logic        trunc;
	logic [31:0] crc;
	logic [13:0] len_cnt;
	logic        vio;
	logic        mcast;
	logic        bcast;
	logic        prior_carrier_event_flag;

	assign byte_done = tick_rise && asm_st == mrbp_pkg::ASM_DATA && rx_line_valid && nib_hi;
	assign new_byte  = {rx_nibble, lo_nib};
	assign sfd_seen  = tick_rise && asm_st == mrbp_pkg::ASM_PRE && rx_line_valid
		&& rx_nibble == `MRBP_SFD_NIB && pre_cnt >= 4'(`MRBP_PRE_MIN);
	assign end_seen  = tick_rise && asm_st == mrbp_pkg::ASM_DATA && !rx_line_valid;
	// Activity that never becomes a receive attempt
	assign carrier_ev = tick_rise && (
		(asm_st == mrbp_pkg::ASM_IDLE && !rx_line_valid && rx_carrier)
		|| (asm_st == mrbp_pkg::ASM_IDLE && rx_line_valid
			&& !(rx_en && ipg_cnt >= IPG_N && rx_nibble == `MRBP_PRE_NIB))
		|| (asm_st == mrbp_pkg::ASM_PRE && !sfd_seen
			&& !(rx_line_valid && rx_nibble == `MRBP_PRE_NIB)));

	// Gap counter runs while the line is quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ipg_cnt <= 5'h00;
		end else if (clk_en && tick_rise) begin
			if (rx_line_valid || rx_carrier) begin
				ipg_cnt <= 5'h00;
			end else if (ipg_cnt < IPG_N) begin
				ipg_cnt <= ipg_cnt + 5'h01;
			end
		end
	end

	// Preamble hunt, only after a full gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asm_st  <= mrbp_pkg::ASM_IDLE;
			pre_cnt <= 4'h0;
		end else if (clk_en && trunc) begin
			asm_st <= mrbp_pkg::ASM_DROP;
		end else if (clk_en && tick_rise) begin
			case (asm_st)
				mrbp_pkg::ASM_IDLE: begin
					pre_cnt <= 4'h1;
					if (rx_line_valid) begin
						asm_st <= carrier_ev ? mrbp_pkg::ASM_DROP : mrbp_pkg::ASM_PRE;
					end
				end
				mrbp_pkg::ASM_PRE: begin
					if (sfd_seen) begin
						asm_st <= mrbp_pkg::ASM_DATA;
					end else if (!rx_line_valid) begin
						asm_st <= mrbp_pkg::ASM_IDLE;
					end else if (rx_nibble == `MRBP_PRE_NIB) begin
						pre_cnt <= (pre_cnt == 4'hF) ? pre_cnt : pre_cnt + 4'h1;
					end else begin
						asm_st <= mrbp_pkg::ASM_DROP;
					end
				end
				mrbp_pkg::ASM_DATA: begin
					if (!rx_line_valid) begin
						asm_st <= mrbp_pkg::ASM_IDLE;
					end
				end
				default: begin
					if (!rx_line_valid) begin
						asm_st <= mrbp_pkg::ASM_IDLE;
					end
				end
			endcase
		end
	end

	// CRC over nibbles, low bit first
	function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
		logic [31:0] r;
		logic        fb;
		r = c;
		for (int i = 0; i < 4; i++) begin
			fb = r[31] ^ d[i];
			r  = {r[30:0], 1'b0} ^ (fb ? `MRBP_CRC_POLY : 32'h0000_0000);
		end
		return r;
	endfunction

	// Per-frame accumulators, cleared at the start delimiter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc     <= `MRBP_CRC_INIT;
			len_cnt <= 14'h0000;
			lo_nib  <= 4'h0;
			nib_hi  <= 1'b0;
			vio     <= 1'b0;
			mcast   <= 1'b0;
			bcast   <= 1'b0;
		end else if (clk_en && sfd_seen) begin
			crc     <= `MRBP_CRC_INIT;
			len_cnt <= 14'h0000;
			nib_hi  <= 1'b0;
			vio     <= rx_line_error;
			mcast   <= 1'b0;
			bcast   <= 1'b1;
		end else if (clk_en && tick_rise && asm_st == mrbp_pkg::ASM_DATA && rx_line_valid) begin
			crc    <= crc_nib(crc, rx_nibble);
			lo_nib <= rx_nibble;
			nib_hi <= ~nib_hi;
			vio    <= vio | rx_line_error;
			if (byte_done) begin
				len_cnt <= (len_cnt == 14'h3FFF) ? len_cnt : len_cnt + 14'h0001;
				if (len_cnt == 14'h0000) begin
					mcast <= new_byte[0];
				end
				if (len_cnt < `MRBP_ADDR_BYTES && new_byte != `MRBP_BCAST_BYTE) begin
					bcast <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Byte pipeline: pending and last byte
	// ****************************************
	mrbp_pkg::mrbp_sch_t sch_st;
	logic [7:0]  hold;
	logic        hold_v;
	logic [7:0]  pend;
	logic        pend_v;
	logic        frame_end;
	logic        take_pend;
	logic        take_hold;
	logic        to_stat;

	// One-byte lag lets the last byte be known before it leaves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold   <= 8'h00;
			hold_v <= 1'b0;
			pend   <= 8'h00;
			pend_v <= 1'b0;
		end else if (clk_en) begin
			if (sfd_seen || trunc) begin
				hold_v <= 1'b0;
				pend_v <= 1'b0;
			end else if (byte_done) begin
				hold   <= new_byte;
				hold_v <= 1'b1;
				pend   <= hold;
				pend_v <= hold_v | (pend_v & ~take_pend);
			end else begin
				if (take_pend) begin
					pend_v <= 1'b0;
				end
				if (take_hold) begin
					hold_v <= 1'b0;
				end
			end
		end
	end

	// End marker waits for the scheduler; a new end wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_end <= 1'b0;
		end else if (clk_en) begin
			frame_end <= end_seen | (frame_end & ~to_stat & ~sfd_seen);
		end
	end

	// Carrier event memory; an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prior_carrier_event_flag <= 1'b0;
		end else if (clk_en) begin
			prior_carrier_event_flag <= carrier_ev | (prior_carrier_event_flag & ~to_stat);
		end
	end

	// ****************************************
	// Status word
	// ****************************************
	logic [23:0] next_stat;
	logic [13:0] st_len;
	logic        runt;
	logic        over;
	logic        drib;
	logic        crc_bad;

	always_comb begin
		st_len  = trunc ? MAX_L : len_cnt;
		runt    = len_cnt < `MRBP_MIN_LEN;
		over    = len_cnt > `MRBP_LONG_LEN;
		drib    = nib_hi;
		crc_bad = crc != `MRBP_CRC_RES;
		next_stat = 24'h00_0000;
		next_stat[`MRBP_ST_LEN_MSB:0] = st_len;
		next_stat[`MRBP_ST_RUNT]  = runt;
		next_stat[`MRBP_ST_OVER]  = over;
		next_stat[`MRBP_ST_VIO]   = vio;
		next_stat[`MRBP_ST_DRIB]  = drib;
		next_stat[`MRBP_ST_CRC]   = crc_bad;
		next_stat[`MRBP_ST_MCAST] = mcast & ~bcast;
		next_stat[`MRBP_ST_BCAST] = bcast & (len_cnt >= `MRBP_ADDR_BYTES);
		next_stat[`MRBP_ST_OK]    = ~(runt | over | vio | drib | crc_bad);
		next_stat[`MRBP_ST_PRIOR_CARRIER_EVENT_FLAG]  = prior_carrier_event_flag;
	end

	// ****************************************
	// Output slot scheduler
	// ****************************************
	logic [13:0] out_cnt;
	logic [1:0]  st_idx;
	logic [23:0] stat_word;
	logic        trunc_now;
	logic [13:0] cnt_prev;

	// Bytes already sent; a new frame must not reuse the previous total
	assign cnt_prev  = (sch_st == mrbp_pkg::SCH_IDLE) ? 14'h0000 : out_cnt;
	// Byte about to reach the limit while more data waits
	assign trunc_now = !ovs_en && cnt_prev + 14'h0001 >= MAX_L;
	assign take_pend = slot && pend_v
		&& (sch_st == mrbp_pkg::SCH_IDLE || sch_st == mrbp_pkg::SCH_DATA);
	assign take_hold = slot && !pend_v && frame_end && hold_v
		&& (sch_st == mrbp_pkg::SCH_IDLE || sch_st == mrbp_pkg::SCH_DATA);
	assign trunc     = take_pend && trunc_now;
	assign to_stat   = slot && (trunc
		|| (take_hold && cnt_prev + 14'h0001 >= `MRBP_MIN_BYTES)
		|| (sch_st == mrbp_pkg::SCH_TAIL && out_cnt + 14'h0001 >= `MRBP_MIN_BYTES));

	// Outputs move only on slots, so each value stands two periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sch_st            <= mrbp_pkg::SCH_IDLE;
			out_cnt           <= 14'h0000;
			st_idx            <= 2'h0;
			stat_word         <= 24'h00_0000;
			rx_byte_bus       <= 8'h00;
			rx_byte_valid     <= 1'b0;
			rx_start_of_frame <= 1'b0;
			rx_end_of_frame   <= 1'b0;
			rx_status_strobe  <= 1'b0;
		end else if (clk_en && slot) begin
			rx_byte_valid     <= 1'b0;
			rx_start_of_frame <= 1'b0;
			rx_end_of_frame   <= 1'b0;
			rx_status_strobe  <= 1'b0;
			if (to_stat) begin
				stat_word <= next_stat;
				st_idx    <= 2'h0;
			end
			case (sch_st)
				mrbp_pkg::SCH_IDLE, mrbp_pkg::SCH_DATA: begin
					if (take_pend || take_hold) begin
						rx_byte_bus       <= take_pend ? pend : hold;
						rx_byte_valid     <= 1'b1;
						rx_start_of_frame <= sch_st == mrbp_pkg::SCH_IDLE;
						rx_end_of_frame   <= to_stat;
						out_cnt <= (sch_st == mrbp_pkg::SCH_IDLE) ? 14'h0001 : out_cnt + 14'h0001;
						if (to_stat) begin
							sch_st <= mrbp_pkg::SCH_STAT;
						end else if (take_hold) begin
							sch_st <= mrbp_pkg::SCH_TAIL;
						end else begin
							sch_st <= mrbp_pkg::SCH_DATA;
						end
					end
				end
				mrbp_pkg::SCH_TAIL: begin
					// Zero filler keeps short frames at the minimum
					rx_byte_bus     <= 8'h00;
					rx_byte_valid   <= 1'b1;
					rx_end_of_frame <= to_stat;
					out_cnt         <= out_cnt + 14'h0001;
					if (to_stat) begin
						sch_st <= mrbp_pkg::SCH_STAT;
					end
				end
				default: begin
					// Low byte first, valid held low
					rx_byte_bus      <= stat_word[8 * st_idx +: 8];
					rx_status_strobe <= 1'b1;
					st_idx           <= st_idx + 2'h1;
					if (st_idx == `MRBP_ST_LAST_IDX) begin
						sch_st <= mrbp_pkg::SCH_IDLE;
					end
				end
			endcase
		end
	end

	// Software view of the last status and frame count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_stat <= 24'h00_0000;
			frame_cnt <= 16'h0000;
		end else if (clk_en && to_stat) begin
			last_stat <= next_stat;
			frame_cnt <= frame_cnt + 16'h0001;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_status_not_valid: assert property (rx_status_strobe |-> !rx_byte_valid)
		else $error("status strobe with byte valid");
	a_status_after_eof: assert property (
		clk_en && slot && rx_end_of_frame |=> rx_status_strobe)
		else $error("status does not follow end of frame");
	a_sof_with_valid: assert property (rx_start_of_frame |-> rx_byte_valid)
		else $error("start strobe without valid");
	a_eof_with_valid: assert property (rx_end_of_frame |-> rx_byte_valid)
		else $error("end strobe without valid");
	a_change_on_slot: assert property (
		$changed(rx_byte_bus) || $changed(rx_byte_valid) |-> $past(slot))
		else $error("port output moved off a byte slot");
	a_min_three: assert property (rx_end_of_frame |-> out_cnt >= 14'h0003)
		else $error("frame shorter than three bytes");
	a_trunc_limit: assert property (rx_byte_valid && !ovs_en |-> out_cnt <= MAX_L)
		else $error("frame passed the length limit");
	a_trunc_eof: assert property (
		rx_byte_valid && !ovs_en && out_cnt == MAX_L |-> rx_end_of_frame)
		else $error("limit byte lacks end strobe");
	a_rsv_zero: assert property (
		rx_status_strobe && st_idx == 2'h3 |-> !rx_byte_bus[7])
		else $error("reserved status bit set");
	a_good_clean: assert property (
		rx_status_strobe && st_idx == 2'h3 && rx_byte_bus[5] |-> rx_byte_bus[2:0] == 3'h0)
		else $error("good frame flag with an error");

	c_full_frame: cover property (rx_end_of_frame && out_cnt > 14'h0003);
	c_short_pad: cover property (rx_end_of_frame && rx_byte_bus == 8'h00 && out_cnt == 14'h0003);
	c_truncated: cover property (trunc);
	c_carrier: cover property (carrier_ev);
endmodule

// >>> mrbp_regs.svh
// Register map, field positions and timing constants of the receive byte port
`ifndef MRBP_REGS_SVH
`define MRBP_REGS_SVH
// ****************************************
// Register offsets and fields
// ****************************************
`define MRBP_CTRL_OFS      8'h00
`define MRBP_STAT_OFS      8'h04
`define MRBP_COUNT_OFS     8'h08
`define MRBP_CTRL_RST      32'h0000_0001
`define MRBP_CTRL_EN_BIT   0
`define MRBP_CTRL_MODE_LSB 1
`define MRBP_CTRL_MODE_MSB 2
`define MRBP_CTRL_OVS_BIT  5
// ****************************************
// Clock rates and line timing
// ****************************************
`define MRBP_CLK_HZ        40000000
`define MRBP_SLOW_HZ       2500000
`define MRBP_FAST_HZ       25000000
`define MRBP_IPG_BITS      96
`define MRBP_BITS_PER_NIB  4
`define MRBP_PRE_MIN       2
`define MRBP_PRE_NIB       4'h5
`define MRBP_SFD_NIB       4'hD
// ****************************************
// Frame limits and checks
// ****************************************
`define MRBP_MAX_LEN       1536
`define MRBP_LONG_LEN      14'h05EE
`define MRBP_MIN_LEN       14'h0040
`define MRBP_ADDR_BYTES    14'h0006
`define MRBP_BCAST_BYTE    8'hFF
`define MRBP_MIN_BYTES     14'h0003
`define MRBP_CRC_POLY      32'h04C1_1DB7
`define MRBP_CRC_INIT      32'hFFFF_FFFF
`define MRBP_CRC_RES       32'hC704_DD7B
// ****************************************
// Status word layout
// ****************************************
`define MRBP_ST_LEN_MSB    13
`define MRBP_ST_RUNT       14
`define MRBP_ST_OVER       15
`define MRBP_ST_VIO        16
`define MRBP_ST_DRIB       17
`define MRBP_ST_CRC        18
`define MRBP_ST_MCAST      19
`define MRBP_ST_BCAST      20
`define MRBP_ST_OK         21
`define MRBP_ST_PRIOR_CARRIER_EVENT_FLAG       22
`define MRBP_ST_RSV        23
`define MRBP_ST_LAST_IDX   2'h2
`endif

// >>> mrbp_pkg.sv
// Types shared by the receive byte port
package mrbp_pkg;
	// Line mode selecting the nibble clock rate
	typedef enum logic [1:0] {
		MRBP_SERIAL10,
		MRBP_CODED100,
		MRBP_MII_SLOW,
		MRBP_MII_FAST
	} mrbp_mode_t;
	// Nibble front end: preamble hunt and byte assembly
	typedef enum logic [1:0] {ASM_IDLE, ASM_PRE, ASM_DATA, ASM_DROP} mrbp_asm_t;
	// Output slot scheduler
	typedef enum logic [1:0] {SCH_IDLE, SCH_DATA, SCH_TAIL, SCH_STAT} mrbp_sch_t;
endpackage

// >>> mrbp_buf_model.sv
// Behavioural receive buffer manager collecting the byte port output
`timescale 1ns/1ps
// ****************************************
// Buffer manager model
// ****************************************
module mrbp_buf_model (
	input wire logic       presetn,
	input wire logic       rx_nibble_clock,
	input wire logic [7:0] rx_byte_bus,
	input wire logic       rx_byte_valid,
	input wire logic       rx_start_of_frame,
	input wire logic       rx_end_of_frame,
	input wire logic       rx_status_strobe
);
	logic [11:0] got[$];
	logic        half;
	// Takes one entry per two nibble clocks, never stalls: no back-pressure
	always @(posedge rx_nibble_clock or negedge presetn) begin
		if (!presetn) begin
			half <= 1'b0;
		end else if (rx_byte_valid | rx_status_strobe) begin
			if (!half) begin
				got.push_back({rx_status_strobe, rx_byte_valid, rx_start_of_frame,
					rx_end_of_frame, rx_byte_bus});
			end
			half <= ~half;
		end else begin
			half <= 1'b0;
		end
	end
endmodule

// >>> mac_receive_byte_port_bench.sv
// Self-checking bench of the receive byte port
`timescale 1ns/1ps
// ****************************************
// Bench top
// ****************************************
module mac_receive_byte_port_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rx_byte_bus;
	logic [31:0] pwdata, prdata;
	logic [3:0]  rx_nibble;
	logic        rx_line_valid, rx_line_error, rx_carrier, rx_nibble_clock;
	logic        rx_byte_valid, rx_start_of_frame, rx_end_of_frame, rx_status_strobe;
	logic        clk_en;
	int          failures, n_tests;
	// Short size limit keeps the truncation case quick
	mrbp_rx_port #(.MAX_LEN(80)) mrbp_rx_port_inst (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_nibble(rx_nibble), .rx_line_valid(rx_line_valid),
		.rx_line_error(rx_line_error), .rx_carrier(rx_carrier),
		.rx_nibble_clock(rx_nibble_clock), .rx_byte_bus(rx_byte_bus),
		.rx_byte_valid(rx_byte_valid), .rx_start_of_frame(rx_start_of_frame),
		.rx_end_of_frame(rx_end_of_frame), .rx_status_strobe(rx_status_strobe));
	mrbp_buf_model mrbp_buf_model_inst (.presetn(presetn), .rx_nibble_clock(rx_nibble_clock),
		.rx_byte_bus(rx_byte_bus), .rx_byte_valid(rx_byte_valid),
		.rx_start_of_frame(rx_start_of_frame), .rx_end_of_frame(rx_end_of_frame),
		.rx_status_strobe(rx_status_strobe));
	// 40 MHz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One APB transfer, held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Line nibble, launched as the nibble clock falls, sampled at its rise
	task nib(input logic [3:0] d, input logic v, input logic c, input logic e);
		@(negedge rx_nibble_clock);
		rx_nibble <= d;
		rx_line_valid <= v;
		rx_carrier <= c;
		rx_line_error <= e;
	endtask
	task idle(input int n);
		repeat (n) nib(4'h0, 1'b0, 1'b0, 1'b0);
	endtask
	function automatic logic [31:0] fcs(input logic [7:0] q[$]);
		logic [31:0] c;
		c = 32'hFFFF_FFFF;
		for (int i = 0; i < q.size(); i++) begin
			c ^= {24'h00_0000, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
		end
		return ~c;
	endfunction
	// Send one frame, then compare every collected byte and status slot
	task run(input logic [7:0] q[$], input int drib, input int err_at, input int nout,
		input logic [23:0] st);
		int w;
		logic [7:0] b;
		mrbp_buf_model_inst.got.delete();
		idle(30);
		repeat (15) nib(4'h5, 1'b1, 1'b1, 1'b0);
		nib(4'hD, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < q.size(); i++) begin
			nib(q[i][3:0], 1'b1, 1'b1, i == err_at);
			nib(q[i][7:4], 1'b1, 1'b1, 1'b0);
		end
		if (drib != 0) nib(4'hA, 1'b1, 1'b1, 1'b0);
		idle(30);
		w = 0;
		while (mrbp_buf_model_inst.got.size() < nout + 3 && w < 2000) begin
			@(posedge pclk);
			w++;
		end
		check(mrbp_buf_model_inst.got.size(), nout + 3);
		for (int i = 0; i < nout + 3 && i < mrbp_buf_model_inst.got.size(); i++) begin
			b = (i >= nout) ? st[8*(i-nout)+:8] : (i < q.size()) ? q[i] : 8'h00;
			check(mrbp_buf_model_inst.got[i], {i >= nout, i < nout, i == 0, i == nout - 1, b});
		end
	endtask
	task t_regs;
		logic [31:0] d;
		logic e;
		check({rx_byte_valid, rx_start_of_frame, rx_end_of_frame, rx_status_strobe}, 0);
		apb(1'b0, 8'h00, 0, d, e);
		check(d, 32'h0000_0001);
		check({pready, pslverr}, 32'h0000_0002);
		apb(1'b0, 8'h0C, 0, d, e);
		check(d, 32'h0000_0000);
		check(e, 32'h0000_0001);
		// A write while the enable is low must not land
		clk_en <= 1'b0;
		apb(1'b1, 8'h00, 32'h0000_000F, d, e);
		clk_en <= 1'b1;
		apb(1'b0, 8'h00, 0, d, e);
		check(d, 32'h0000_0001);
	endtask
	// Nibble period in pclk cycles, slow then fast mode
	task t_rate;
		realtime t;
		logic [31:0] d;
		logic e;
		@(posedge rx_nibble_clock) t = $realtime;
		@(posedge rx_nibble_clock) check(($realtime - t) / 25.0, 16);
		apb(1'b1, 8'h00, 32'h0000_0007, d, e);
		apb(1'b0, 8'h00, 0, d, e);
		check(d, 32'h0000_0007);
		@(posedge rx_nibble_clock) t = $realtime;
		@(posedge rx_nibble_clock) check(($realtime - t) / 25.0, 2);
	endtask
	task t_good;
		logic [7:0] q[$];
		logic [31:0] c;
		for (int i = 0; i < 60; i++) q.push_back(i < 6 ? 8'hFF : 8'(i));
		c = fcs(q);
		for (int i = 0; i < 4; i++) q.push_back(c[8*i+:8]);
		run(q, 0, -1, 64, 24'h30_0040);
	endtask
	// Stray carrier, then a one-byte frame padded to three
	task t_event;
		logic [7:0] q[$];
		idle(30);
		repeat (3) nib(4'h0, 1'b0, 1'b1, 1'b0);
		q.push_back(8'h02);
		run(q, 0, -1, 3, 24'h44_4001);
	endtask
	task t_error;
		logic [7:0] q[$];
		for (int i = 0; i < 10; i++) q.push_back(i == 0 ? 8'h01 : 8'(i));
		run(q, 1, 3, 10, 24'h0F_400A);
	endtask
	task t_trunc;
		logic [7:0] q[$];
		logic [31:0] d;
		logic e;
		for (int i = 0; i < 90; i++) q.push_back(8'(i + 2));
		run(q, 0, -1, 80, 24'h04_0050);
		apb(1'b1, 8'h00, 32'h0000_0027, d, e);
		run(q, 0, -1, 90, 24'h04_005A);
		apb(1'b0, 8'h04, 0, d, e);
		check(d, 32'h0004_005A);
		apb(1'b0, 8'h08, 0, d, e);
		check(d, 32'h0000_0005);
	endtask
	// Oversize flag with the size limit lifted
	task t_long;
		logic [7:0] q[$];
		for (int i = 0; i < 1519; i++) q.push_back(8'(i + 2));
		run(q, 0, -1, 1519, 24'h04_85EF);
	endtask
	// Cuts a hang short well past the expected run time
	initial begin
		#1000000;
		failures++;
		final_report;
	end
	initial begin
		failures = 0;
		n_tests = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		{rx_nibble, rx_line_valid, rx_line_error, rx_carrier} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_rate;
		t_good;
		t_event;
		t_error;
		t_trunc;
		t_long;
		final_report;
	end
endmodule
